// File: rtl/pvi_pkg.sv
// Function
// - Twenty sources: eight pins, eleven peripherals, break
// - Take only when requested, enabled, flag clear
// - Software sets and clears every enable bit
// - Software clears requests; only hardware sets them
// - Reset and break ignore flag and enables
// - Lowest priority number wins among pending requests
// - Halt core, push program counter and status
// - Fetch vector during push, load program counter
// - Acceptance sets disable flag, clears request bit
// - Reset is priority one, vector at top
// - Four edge pins at priorities 2,3,10,11
// - Serial one receive 4, transmit 5, if selected
// - Timers X and Y underflow at 6, 7
// - Slot 8 takes input d or timer two
// - Slot 9 takes input e or timer three
// - Slot 13 takes input c or timer one
// - Serial two completion at 12 when selected
// - Output timers A and B at 14, 15
// - Slot 16 converter done or trigger falling edge
// - Break instruction is priority 17, non-maskable
// - Vector low byte even, high byte odd
`default_nettype none
package pvi_pkg;
    // Register byte offsets on the APB slave.
    localparam logic [7:0] PVI_OFS_REQ = 8'h00;
    localparam logic [7:0] PVI_OFS_ENABLE = 8'h04;
    localparam logic [7:0] PVI_OFS_EDGE = 8'h08;
    localparam logic [7:0] PVI_OFS_SELECT = 8'h0C;
    localparam logic [7:0] PVI_OFS_STATUS = 8'h10;
    // Counts of maskable slots (priorities 2 to 16) and edge pins.
    localparam int PVI_NSLOT = 15;
    localparam int PVI_NPIN = 7;
    // Priority numbers of the special slots.
    localparam logic [4:0] PVI_PRI_RESET = 5'h01;
    localparam logic [4:0] PVI_PRI_FIRST = 5'h02;
    localparam logic [4:0] PVI_PRI_BREAK = 5'h11;
    // Vector of priority one; every lower priority sits one word below.
    localparam logic [15:0] PVI_VEC_TOP = 16'hFFFC;
    // Stack lives in page one; a full push is three bytes.
    localparam logic [7:0] PVI_STACK_PAGE = 8'h01;
    localparam logic [7:0] PVI_PUSH_BYTES = 8'h03;
    // Select register bit positions.
    localparam int PVI_SEL_SLOT8 = 0;
    localparam int PVI_SEL_SLOT9 = 1;
    localparam int PVI_SEL_SLOT13 = 2;
    localparam int PVI_SEL_SLOT16 = 3;
    localparam int PVI_SEL_SER1 = 4;
    localparam int PVI_SEL_SER2 = 5;
    localparam int PVI_SEL_ADTRIG = 6;
    localparam int PVI_NSEL = 7;
    // Status register bit positions.
    localparam int PVI_ST_FLAG = 0;
    localparam int PVI_ST_BUSY = 1;
    localparam int PVI_ST_SLOT_LSB = 4;
    // Acceptance sequence, Gray coded from idle to load; the step from load back to idle flips two bits.
    typedef enum logic [2:0] {
        PVI_IDLE = 3'h0,
        PVI_PUSH_HI = 3'h1,
        PVI_PUSH_LO = 3'h3,
        PVI_PUSH_PS = 3'h2,
        PVI_LOAD = 3'h6
    } pvi_state_e;
    // Edge pins: a, b, c, d, e, counter a, counter b, plus converter trigger.
    typedef struct packed {
        logic converter_trigger_pin;
        logic counter_pin_b;
        logic counter_pin_a;
        logic ext_edge_in_e;
        logic ext_edge_in_d;
        logic ext_edge_in_c;
        logic ext_edge_in_b;
        logic ext_edge_in_a;
    } pvi_pins_s;
    // One-cycle event pulses from the peripherals.
    typedef struct packed {
        logic ser1_rx_done;
        logic ser1_tx_done;
        logic timer_x_uf;
        logic timer_y_uf;
        logic timer_1_uf;
        logic timer_2_uf;
        logic timer_3_uf;
        logic ser2_done;
        logic timer_a_uf;
        logic timer_b_uf;
        logic adc_done;
    } pvi_periph_s;
    // Core state offered to the unit.
    typedef struct packed {
        logic [15:0] pc;
        logic [7:0] ps;
        logic [7:0] sp;
        logic instr_boundary;
        logic break_instruction;
        logic flag_set;
        logic flag_clear;
    } pvi_core_s;
    // Stack write port.
    typedef struct packed {
        logic we;
        logic [15:0] addr;
        logic [7:0] wdata;
    } pvi_stack_s;
endpackage
`default_nettype wire

// File: rtl/pvi_unit.sv
`default_nettype none
// Prioritised vector interrupt unit with APB register access.
module pvi_unit (
    input wire logic clk_sys,
    input wire logic reset_n,
    // APB slave port.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Event sources: pin levels and peripheral pulses.
    input wire pvi_pkg::pvi_pins_s pins,
    input wire pvi_pkg::pvi_periph_s periph,
    // Core handshake and stack writes.
    input wire pvi_pkg::pvi_core_s core,
    output logic core_halt,
    output logic irq_disable,
    output pvi_pkg::pvi_stack_s stack,
    output logic sp_adjust,
    // Vector fetch and program counter load.
    output logic vec_rd,
    output logic [15:0] vec_addr,
    input wire logic [7:0] vec_data,
    output logic pc_load,
    output logic [15:0] pc_value
);
    // Software-visible state.
    logic [pvi_pkg::PVI_NSLOT-1:0] req; // Request bits, bit k is priority k+2.
    logic [pvi_pkg::PVI_NSLOT-1:0] enable; // Enable bits, same layout.
    logic [pvi_pkg::PVI_NPIN-1:0] edge_pol; // One selects the rising edge.
    logic [pvi_pkg::PVI_NSEL-1:0] src_sel; // Shared-slot and function selects.
    logic flag; // Global disable flag.
    logic break_pend; // Latched break request.

    // Sequence state.
    pvi_pkg::pvi_state_e state; // Acceptance sequence position.
    pvi_pkg::pvi_state_e next_state; // Its next value.
    logic [4:0] act_slot; // Priority number being served.
    logic push_en; // Low only for the reset fetch, which pushes nothing.
    logic [7:0] vec_lo; // Captured low vector byte.
    logic [7:0] vec_hi; // Captured high vector byte.

    // Pin history for edge detection.
    logic [7:0] pin_prev; // Pins one cycle ago.
    logic pin_valid; // History is meaningful.

    // Decoded bus strobes.
    wire logic setup_ph = psel & ~penable; // Setup cycle of a transfer.
    wire logic access_ph = psel & penable; // Access cycle of a transfer.

    // Address match for each register word.
    // Only the exact byte address matches; nothing aliases.
    wire logic hit_req = paddr == pvi_pkg::PVI_OFS_REQ;
    wire logic hit_en = paddr == pvi_pkg::PVI_OFS_ENABLE;
    wire logic hit_edge = paddr == pvi_pkg::PVI_OFS_EDGE;
    wire logic hit_sel = paddr == pvi_pkg::PVI_OFS_SELECT;
    wire logic hit_stat = paddr == pvi_pkg::PVI_OFS_STATUS;

    // Any hit means the address is mapped.
    wire logic mapped = hit_req | hit_en | hit_edge | hit_sel | hit_stat;

    // Write strobes live in the access cycle only.
    // A write lands on the edge that ends that cycle.
    wire logic wr_req = access_ph & pwrite & hit_req;
    wire logic wr_en = access_ph & pwrite & hit_en;
    wire logic wr_edge = access_ph & pwrite & hit_edge;
    wire logic wr_sel = access_ph & pwrite & hit_sel;

    // Every transfer completes in its first access cycle.
    assign pready = access_ph;
    // Unmapped addresses answer with an error, and status is read only.
    assign pslverr = access_ph & (~mapped | (pwrite & hit_stat));

    // Current pin levels in edge-register order.
    wire logic [pvi_pkg::PVI_NPIN-1:0] pin_now = pins[pvi_pkg::PVI_NPIN-1:0];
    wire logic [pvi_pkg::PVI_NPIN-1:0] pin_old = pin_prev[pvi_pkg::PVI_NPIN-1:0];
    wire logic [pvi_pkg::PVI_NPIN-1:0] pin_hit; // Selected edge seen on a pin, one net per bit.

    // Each pin watches the edge that software chose for it.
    genvar gp;
    generate
        for (gp = 0; gp < pvi_pkg::PVI_NPIN; gp++) begin : g_edge
            assign pin_hit[gp] = pin_valid & (edge_pol[gp] ? (pin_now[gp] & ~pin_old[gp]) :
                                                             (~pin_now[gp] & pin_old[gp]));
        end
    endgenerate

    // The converter trigger counts only on a falling edge.
    wire logic trig_fall = pin_valid & pin_prev[pvi_pkg::PVI_NPIN] &
        ~pins.converter_trigger_pin;

    // Shared slots pick one of two sources; the other cannot reach the slot.
    wire logic src8 = src_sel[pvi_pkg::PVI_SEL_SLOT8] ? periph.timer_2_uf : pin_hit[3];
    wire logic src9 = src_sel[pvi_pkg::PVI_SEL_SLOT9] ? periph.timer_3_uf : pin_hit[4];
    wire logic src13 = src_sel[pvi_pkg::PVI_SEL_SLOT13] ? periph.timer_1_uf : pin_hit[2];
    wire logic trig_ok = trig_fall & src_sel[pvi_pkg::PVI_SEL_ADTRIG];
    wire logic src16 = src_sel[pvi_pkg::PVI_SEL_SLOT16] ? trig_ok : periph.adc_done;

    // Serial requests count only while their function is on.
    wire logic ser1_on = src_sel[pvi_pkg::PVI_SEL_SER1];
    wire logic ser2_on = src_sel[pvi_pkg::PVI_SEL_SER2];

    // Hardware events per maskable slot; every pin and peripheral source gathers here, break is latched apart.
    wire logic [pvi_pkg::PVI_NSLOT-1:0] hw_set = {
        src16, // Priority 16.
        periph.timer_b_uf, // Priority 15.
        periph.timer_a_uf, // Priority 14.
        src13, // Priority 13.
        periph.ser2_done & ser2_on, // Priority 12.
        pin_hit[6], // Priority 11, counter pin b.
        pin_hit[5], // Priority 10, counter pin a.
        src9, // Priority 9.
        src8, // Priority 8.
        periph.timer_y_uf, // Priority 7.
        periph.timer_x_uf, // Priority 6.
        periph.ser1_tx_done & ser1_on, // Priority 5.
        periph.ser1_rx_done & ser1_on, // Priority 4.
        pin_hit[1], // Priority 3.
        pin_hit[0] // Priority 2.
    };

    // Maskable candidates need request, enable and a clear flag.
    wire logic [pvi_pkg::PVI_NSLOT-1:0] live = req & enable &
        {pvi_pkg::PVI_NSLOT{~flag}};

    // Picks the lowest set bit, that is the smallest priority number.
    function automatic logic [4:0] pick(input logic [pvi_pkg::PVI_NSLOT-1:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = pvi_pkg::PVI_NSLOT - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = pvi_pkg::PVI_PRI_FIRST + 5'(i);
            end
        end
        return r;
    endfunction

    // Break sits below every maskable slot and ignores the flag.
    wire logic [4:0] mask_pick = pick(live);
    wire logic [4:0] cand = (mask_pick != 5'h00) ? mask_pick :
                            (break_pend ? pvi_pkg::PVI_PRI_BREAK : 5'h00);
    // Acceptance waits for an instruction boundary in the core.
    wire logic accept = (state == pvi_pkg::PVI_IDLE) & core.instr_boundary &
        (cand != 5'h00);

    // One-hot clear of the accepted maskable slot.
    wire logic [4:0] cand_idx = cand - pvi_pkg::PVI_PRI_FIRST;
    wire logic cand_mask = accept & (cand != pvi_pkg::PVI_PRI_BREAK);
    wire logic [pvi_pkg::PVI_NSLOT-1:0] acc_clr = cand_mask ?
        (pvi_pkg::PVI_NSLOT'(1) << cand_idx) : '0;

    // Software writes zero to clear a request; a one leaves it alone.
    wire logic [pvi_pkg::PVI_NSLOT-1:0] sw_clr = wr_req ?
        ~pwdata[pvi_pkg::PVI_NSLOT-1:0] : '0;

    // Request bits: set wins over any clear in the same cycle.
    genvar gs;
    generate
        for (gs = 0; gs < pvi_pkg::PVI_NSLOT; gs++) begin : g_req
            always_ff @(posedge clk_sys) begin
                if (!reset_n) begin
                    req[gs] <= 1'b0;
                end else begin
                    // Set by its event whatever the enable, held until cleared.
                    req[gs] <= hw_set[gs] | (req[gs] & ~sw_clr[gs] & ~acc_clr[gs]);
                end
            end
        end
    endgenerate

    // Configuration registers, all freely written by software.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            enable <= '0;
            edge_pol <= '0;
            src_sel <= '0;
        end else begin
            // Enables are plain read-write bits.
            if (wr_en) begin
                enable <= pwdata[pvi_pkg::PVI_NSLOT-1:0];
            end
            // Changing an edge cannot fake an event; only a change of pin level hits.
            if (wr_edge) begin
                edge_pol <= pwdata[pvi_pkg::PVI_NPIN-1:0];
            end
            // Selects steer shared slots and gate serial and trigger sources.
            if (wr_sel) begin
                src_sel <= pwdata[pvi_pkg::PVI_NSEL-1:0];
            end
        end
    end

    // Pin history; the first cycle after reset detects nothing.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pin_prev <= 8'h00;
            pin_valid <= 1'b0;
        end else begin
            pin_prev <= pins;
            pin_valid <= 1'b1;
        end
    end

    // Break request latch; a new break wins over the acceptance clear.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            break_pend <= 1'b0;
        end else begin
            break_pend <= core.break_instruction |
                          (break_pend & ~(accept & (cand == pvi_pkg::PVI_PRI_BREAK)));
        end
    end

    // Disable flag: acceptance sets it, the core may set or clear it.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            flag <= 1'b1;
        end else if (accept | core.flag_set) begin
            flag <= 1'b1;
        end else if (core.flag_clear) begin
            flag <= 1'b0;
        end
    end

    // Sequence steering.
    always_comb begin
        next_state = state;
        case (state)
            pvi_pkg::PVI_IDLE: begin
                // Stop the core and start pushing.
                if (accept) begin
                    next_state = pvi_pkg::PVI_PUSH_HI;
                end
            end
            pvi_pkg::PVI_PUSH_HI: begin
                // Low vector byte read, counter high byte pushed.
                next_state = pvi_pkg::PVI_PUSH_LO;
            end
            pvi_pkg::PVI_PUSH_LO: begin
                // High vector byte read, counter low byte pushed.
                next_state = pvi_pkg::PVI_PUSH_PS;
            end
            pvi_pkg::PVI_PUSH_PS: begin
                // Status pushed while the high byte arrives.
                next_state = pvi_pkg::PVI_LOAD;
            end
            pvi_pkg::PVI_LOAD: begin
                // The core takes the new counter.
                next_state = pvi_pkg::PVI_IDLE;
            end
            default: begin
                // An unused code falls back to idle.
                next_state = pvi_pkg::PVI_IDLE;
            end
        endcase
    end

    // Leaving reset starts a fetch of priority one without pushing.
    // Reset acts as the top interrupt, so its fetch is set up while
    // reset is held and runs out on the first free edges.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state <= pvi_pkg::PVI_PUSH_HI;
            act_slot <= pvi_pkg::PVI_PRI_RESET;
            push_en <= 1'b0;
        end else begin
            state <= next_state;
            if (accept) begin
                act_slot <= cand;
                push_en <= 1'b1;
            end
        end
    end

    // Vector bytes arrive one cycle after each read.
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            vec_lo <= 8'h00;
            vec_hi <= 8'h00;
        end else begin
            if (state == pvi_pkg::PVI_PUSH_LO) begin
                vec_lo <= vec_data;
            end
            if (state == pvi_pkg::PVI_PUSH_PS) begin
                vec_hi <= vec_data;
            end
        end
    end

    // Slot address: one word below the top for each priority step.
    wire logic [15:0] slot_base = pvi_pkg::PVI_VEC_TOP -
                                  {10'h000, act_slot - pvi_pkg::PVI_PRI_RESET, 1'b0};
    // Low byte at the even address, high byte at the odd one.
    wire logic rd_lo = state == pvi_pkg::PVI_PUSH_HI;
    wire logic rd_hi = state == pvi_pkg::PVI_PUSH_LO;
    assign vec_rd = rd_lo | rd_hi;
    assign vec_addr = rd_hi ? (slot_base | 16'h0001) : slot_base;

    // Stack writes run alongside the vector reads.
    wire logic in_push = rd_lo | rd_hi | (state == pvi_pkg::PVI_PUSH_PS);
    wire logic [7:0] push_ofs = rd_lo ? 8'h00 : (rd_hi ? 8'h01 : 8'h02);
    // One assignment drives the whole stack port, so it has a single driver.
    assign stack = '{
        we: in_push & push_en,
        addr: {pvi_pkg::PVI_STACK_PAGE, core.sp - push_ofs},
        wdata: rd_lo ? core.pc[15:8] : (rd_hi ? core.pc[7:0] : core.ps)
    };
    // The core lowers its stack pointer by three when loading, except after the reset fetch, which pushed nothing.
    assign sp_adjust = (state == pvi_pkg::PVI_LOAD) & push_en;

    // Core is held for the whole sequence; the vector lands at the end.
    assign core_halt = state != pvi_pkg::PVI_IDLE;
    assign pc_load = state == pvi_pkg::PVI_LOAD;
    assign pc_value = {vec_hi, vec_lo};
    // The flag goes straight to the core with no extra delay.
    assign irq_disable = flag;

    // Read data is captured in the setup cycle and held through access.
    // Status shows the flag, busy and the last priority served.
    wire logic [31:0] stat_word = {23'h000000, act_slot, 2'h0,
        core_halt, flag};
    wire logic [31:0] rd_mux = hit_req ? {17'h00000, req} :
                               hit_en ? {17'h00000, enable} :
                               hit_edge ? {25'h0000000, edge_pol} :
                               hit_sel ? {25'h0000000, src_sel} :
                               hit_stat ? stat_word : 32'h00000000;
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            prdata <= 32'h00000000;
        end else if (setup_ph & ~pwrite) begin
            prdata <= rd_mux;
        end
    end
endmodule // pvi_unit
`default_nettype wire

// File: sim/pvi_unit_sva.sv
`default_nettype none
// Checker for the acceptance sequence, seen only from the unit's ports.
module pvi_unit_sva (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire pvi_pkg::pvi_core_s core,
    input wire logic core_halt,
    input wire logic irq_disable,
    input wire pvi_pkg::pvi_stack_s stack,
    input wire logic sp_adjust,
    input wire logic vec_rd,
    input wire logic [15:0] vec_addr,
    input wire logic pc_load
);
    // One clock domain, so clocking and reset qualification are declared once.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // A sequence keeps the core halted for exactly four cycles.
    halt_len_a: assert property ($rose(core_halt) |-> core_halt [*4] ##1 !core_halt)
        else $error("halt length wrong");
    // The first push writes the high byte of the program counter at the stack pointer.
    push_hi_a: assert property ($rose(core_halt) |-> stack.we && stack.wdata == core.pc[15:8]
        && stack.addr == {pvi_pkg::PVI_STACK_PAGE, core.sp}) else $error("first push wrong");
    // The status byte is the third push, two below the pointer.
    push_ps_a: assert property ($rose(core_halt) |-> ##2 stack.we && stack.wdata == core.ps
        && stack.addr == {pvi_pkg::PVI_STACK_PAGE, core.sp - 8'h02}) else $error("status push wrong");
    // The vector is fetched while the push runs: low byte first, then high.
    vec_pair_a: assert property ($rose(core_halt) |-> vec_rd ##1 vec_rd
        && vec_addr == $past(vec_addr) + 16'h0001) else $error("vector fetch wrong");
    // A fetch always starts at the even byte of a slot.
    vec_even_a: assert property (vec_rd && !$past(vec_rd) |-> !vec_addr[0])
        else $error("vector fetch starts odd");
    // Only the seventeen slots at the top of memory are ever read.
    vec_range_a: assert property (vec_rd |-> vec_addr >= 16'hFFDC)
        else $error("vector outside table");
    // The program counter is loaded and the pointer moved at the end of an interrupt.
    pc_load_a: assert property ($rose(core_halt) |-> ##3 pc_load && sp_adjust)
        else $error("program counter not loaded");
    // Acceptance has already set the global disable flag.
    flag_set_a: assert property ($rose(core_halt) |-> irq_disable)
        else $error("disable flag not set");
    // Leaving reset fetches the top slot and loads it without any push.
    reset_vec_a: assert property ($rose(reset_n) |-> vec_addr == 16'hFFFC ##1 vec_addr == 16'hFFFD
        ##2 pc_load && !sp_adjust && !stack.we) else $error("reset vector wrong");
endmodule // pvi_unit_sva
bind pvi_unit pvi_unit_sva pvi_unit_sva_i (.clk_sys(clk_sys), .reset_n(reset_n), .core(core),
    .core_halt(core_halt), .irq_disable(irq_disable), .stack(stack), .sp_adjust(sp_adjust),
    .vec_rd(vec_rd), .vec_addr(vec_addr), .pc_load(pc_load));
`default_nettype wire

// File: sim/pvi_vec_model.sv
`default_nettype none
// Vector memory on the core side; answers the cycle after each read strobe.
module pvi_vec_model (
    input wire logic clk_sys,
    input wire logic vec_rd,
    input wire logic [15:0] vec_addr,
    output logic [7:0] vec_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // Each byte is its address pattern, so a wrong slot or byte order shows at once.
    // Between reads the bus toggles, so a late capture never sees a stale byte.
    always_ff @(posedge clk_sys) begin
        if (vec_rd) begin
            vec_data <= vec_addr[7:0] ^ 8'hA5;
        end else begin
            vec_data <= ~vec_data;
        end
    end
endmodule // pvi_vec_model
`default_nettype wire

// File: sim/pvi_unit_test.sv
`default_nettype none
// Register and acceptance tests of the interrupt unit.
module pvi_unit_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0; // System clock, 50 MHz.
    logic reset_n = 1'b0; // Active low reset.
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    pvi_pkg::pvi_pins_s pins = '0;
    pvi_pkg::pvi_periph_s periph = '0;
    pvi_pkg::pvi_core_s core = '{16'h1234, 8'h5A, 8'hF0, 1'b1, 1'b0, 1'b0, 1'b0};
    logic core_halt;
    logic irq_disable;
    pvi_pkg::pvi_stack_s stack;
    logic sp_adjust;
    logic vec_rd;
    logic [15:0] vec_addr;
    logic [7:0] vec_data;
    logic pc_load;
    logic [15:0] pc_value;
    int fail_count = 0;
    int total_checks = 0;
    logic [31:0] q; // Last read data.
    logic e; // Last error response.
    // Request bit reached by each peripheral pulse, from adc_done upward.
    int pb [11] = '{14, 13, 12, 10, 7, 6, 11, 5, 4, 3, 2};
    // Request bit reached by each edge pin, from ext_edge_in_a upward.
    int nb [7] = '{0, 1, 11, 6, 7, 8, 9};
    pvi_unit pvi_unit_i (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins(pins), .periph(periph), .core(core), .core_halt(core_halt),
        .irq_disable(irq_disable), .stack(stack), .sp_adjust(sp_adjust), .vec_rd(vec_rd),
        .vec_addr(vec_addr), .vec_data(vec_data), .pc_load(pc_load), .pc_value(pc_value));
    pvi_vec_model pvi_vec_model_i (.clk_sys(clk_sys), .vec_rd(vec_rd), .vec_addr(vec_addr),
        .vec_data(vec_data));
    // Free running clock.
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    // Expected jump target of a priority, built the way the vector model fills memory.
    function automatic logic [15:0] vexp(input int p);
        logic [15:0] b;
        b = 16'hFFFC - 16'(2 * (p - 1));
        return {(b[7:0] + 8'h01) ^ 8'hA5, b[7:0] ^ 8'hA5};
    endfunction
    // Compares and counts; reports a mismatch at once.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; the request is held until pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Fires events, lets the request land, checks it and clears it again.
    task automatic ev(input logic [10:0] p, input logic [7:0] pv, input logic [14:0] x);
        @(posedge clk_sys);
        periph <= p;
        pins <= pv;
        @(posedge clk_sys);
        periph <= '0;
        repeat (3) @(posedge clk_sys);
        apb(1'b0, pvi_pkg::PVI_OFS_REQ, 32'h0);
        chk(q, {17'h0, x});
        apb(1'b1, pvi_pkg::PVI_OFS_REQ, 32'h0);
    endtask
    // Pulses the core's break, flag-set and flag-clear strobes for one cycle.
    task automatic kick(input logic [2:0] m);
        @(posedge clk_sys);
        core[2:0] <= m;
        @(posedge clk_sys);
        core[2:0] <= 3'h0;
    endtask
    // Waits a bounded time for the program counter load and checks the target.
    task automatic wait_load(input logic [15:0] x);
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (pc_load !== 1'b1 && n < 30);
        chk({31'h0, pc_load}, 32'h1);
        chk({16'h0, pc_value}, {16'h0, x});
    endtask
    // Verdict; the only place the run ends.
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // A hang is cut short at 20000 cycles, well beyond the few hundred cycles the tests need.
    initial begin
        #400000;
        fail_count++;
        end_sim();
    end
    // Main sequence.
    initial begin
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        wait_load(vexp(1));
        chk({31'h0, irq_disable}, 32'h1);
        apb(1'b1, pvi_pkg::PVI_OFS_ENABLE, 32'h5A5A);
        apb(1'b0, pvi_pkg::PVI_OFS_ENABLE, 32'h0);
        chk(q, 32'h5A5A);
        apb(1'b1, pvi_pkg::PVI_OFS_ENABLE, 32'h0);
        apb(1'b0, pvi_pkg::PVI_OFS_ENABLE, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, pvi_pkg::PVI_OFS_STATUS, 32'h0);
        chk({31'h0, e}, 32'h1);
        // Software ones must not set requests; only a zero clears them.
        periph <= 11'h100;
        @(posedge clk_sys);
        periph <= '0;
        repeat (3) @(posedge clk_sys);
        apb(1'b1, pvi_pkg::PVI_OFS_REQ, 32'h7FFF);
        apb(1'b0, pvi_pkg::PVI_OFS_REQ, 32'h0);
        chk(q, 32'h10);
        apb(1'b1, pvi_pkg::PVI_OFS_REQ, 32'h0);
        apb(1'b0, pvi_pkg::PVI_OFS_REQ, 32'h0);
        chk(q, 32'h0);
        // Selection changes happen with every enable off, then stale requests are cleared.
        apb(1'b1, pvi_pkg::PVI_OFS_EDGE, 32'h7F);
        apb(1'b1, pvi_pkg::PVI_OFS_SELECT, 32'h37);
        apb(1'b1, pvi_pkg::PVI_OFS_REQ, 32'h0);
        for (int i = 0; i < 11; i++) begin
            ev(11'(1 << i), 8'h00, 15'(1 << pb[i]));
        end
        apb(1'b1, pvi_pkg::PVI_OFS_SELECT, 32'h78);
        apb(1'b1, pvi_pkg::PVI_OFS_REQ, 32'h0);
        ev(11'h020, 8'h00, 15'h0);
        for (int i = 0; i < 7; i++) begin
            ev(11'h0, 8'(1 << i), 15'(1 << nb[i]));
            ev(11'h0, 8'h00, 15'h0);
        end
        // Falling polarity: a rise is ignored, the fall is taken.
        apb(1'b1, pvi_pkg::PVI_OFS_EDGE, 32'h0);
        ev(11'h0, 8'h01, 15'h0);
        ev(11'h0, 8'h00, 15'h1);
        ev(11'h0, 8'h80, 15'h0);
        ev(11'h0, 8'h00, 15'h4000);
        // Two requests at once with the flag still set: nothing may be taken.
        apb(1'b1, pvi_pkg::PVI_OFS_ENABLE, 32'h7FFF);
        periph <= 11'h480;
        @(posedge clk_sys);
        periph <= '0;
        repeat (4) @(posedge clk_sys);
        apb(1'b0, pvi_pkg::PVI_OFS_REQ, 32'h0);
        chk(q, 32'h24);
        kick(3'h1);
        wait_load(vexp(4));
        chk({31'h0, irq_disable}, 32'h1);
        apb(1'b0, pvi_pkg::PVI_OFS_REQ, 32'h0);
        chk(q, 32'h20);
        kick(3'h1);
        wait_load(vexp(7));
        apb(1'b0, pvi_pkg::PVI_OFS_REQ, 32'h0);
        chk(q, 32'h0);
        // Break is taken although the flag is set.
        kick(3'h4);
        wait_load(vexp(17));
        apb(1'b0, pvi_pkg::PVI_OFS_STATUS, 32'h0);
        chk(q, 32'h111);
        end_sim();
    end
endmodule // pvi_unit_test
`default_nettype wire
